// [src/fmbt_top.sv]
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/100ps
module fmbt_top (
  // Clock, reset, enable
  input  wire logic                    CLK,
  input  wire logic                    RST,
  input  wire logic                    CE,
  // APB slave
  input  wire fmbt_pkg::fmbt_apb_req_t APB_REQ,
  output logic [31:0]                  PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  // Link sequencing
  input  wire fmbt_pkg::fmbt_link_in_t LINK_IN,
  output logic                         TX_GO,
  output logic                         TX_RETRY,
  output logic                         STN_DEAD,
  output logic [6:0]                   POLL_ADDR,
  output logic                         BIT_TICK,
  // Parameterisation and watchdog
  output logic [17:0]                  PRM_WD_MS,
  output logic                         PRM_WD_EN,
  output logic                         DX_ALLOW
);

  typedef struct packed {
    fmbt_pkg::fmbt_cfg_t   cfg;
    fmbt_pkg::fmbt_state_t st;
    logic [17:0]           cnt;
    logic [11:0]           div_cnt;
    logic                  tick;
    logic [3:0]            retry_cnt;
    logic                  rpt;
    logic                  noack;
    logic [6:0]            poll;
    logic [15:0]           max_delay;
    logic                  dx;
    logic                  dead;
    logic                  go;
    logic [17:0]           wd_out;
    logic [31:0]           prdata;
    logic                  pslverr;
  } fmbt_regs_t;

  fmbt_regs_t r;
  fmbt_regs_t n;

  function automatic logic [17:0] max18(input logic [17:0] a, input logic [17:0] b);
    max18 = (a > b) ? a : b;
  endfunction

  // Derived timing values
  logic        type2;
  logic [11:0] div_eff;
  logic        rate_ok;
  logic        run;
  logic [8:0]  sum_b;
  logic [15:0] slot_eff;
  logic [19:0] slot_min;
  logic        slot_ok;
  logic [17:0] idle1;
  logic [17:0] idle2;
  logic        many;
  assign type2    = r.cfg.ctrl[fmbt_pkg::CTRL_T2];
  assign div_eff  = type2 ? r.cfg.div : fmbt_pkg::DP_BIT_CYC;
  assign rate_ok  = !type2 || (r.cfg.div >= fmbt_pkg::T2_DIV_MIN &&
                               r.cfg.div <= fmbt_pkg::T2_DIV_MAX);
  assign run      = r.cfg.ctrl[fmbt_pkg::CTRL_EN] && rate_ok;
  assign sum_b    = {1'b0, r.cfg.request_payload_bytes} +
                    {1'b0, r.cfg.response_payload_bytes};
  assign slot_eff = !r.cfg.ctrl[fmbt_pkg::CTRL_AUTO] ? r.cfg.slot :
                    (sum_b < fmbt_pkg::SLOT_BIG_BYTES) ? fmbt_pkg::SLOT_STD :
                    fmbt_pkg::SLOT_BIG;
  assign slot_min = 20'(sum_b) * fmbt_pkg::SLOT_BYTE_MUL +
                    20'(r.cfg.tsdr_min) * fmbt_pkg::SLOT_TSDR_MUL +
                    fmbt_pkg::SLOT_MARGIN;
  assign slot_ok  = 20'(slot_eff) > slot_min;
  assign idle1    = 18'({r.cfg.tset, 1'b0}) + 18'(r.cfg.tqui) + fmbt_pkg::IDLE1_ADD +
                    18'(r.cfg.idle1_extra);
  assign idle2    = (18'(r.cfg.tsdr_max) > idle1) ? 18'(r.cfg.tsdr_max) :
                    18'(r.cfg.tid2);
  assign many     = type2 && (r.cfg.stations >= fmbt_pkg::MANY_STATIONS);

  // Watchdog sizing
  logic [17:0] worst_case_delay;
  logic [17:0] wd_base;
  logic [17:0] wd_auto;
  logic [17:0] wd_eff;
  logic        wd_ok;
  assign worst_case_delay = 18'(r.cfg.dp_ms) + 18'(r.cfg.field_ms);
  assign wd_base = r.cfg.ctrl[fmbt_pkg::CTRL_PERSLV] ? worst_case_delay :
                   max18(worst_case_delay, 18'(r.max_delay));
  assign wd_auto = max18(18'(r.cfg.field_ms) * fmbt_pkg::WD_MUL,
                         wd_base + 18'h00001);
  assign wd_eff  = (r.cfg.wd_ms != 16'h0000) ? 18'(r.cfg.wd_ms) :
                   type2 ? fmbt_pkg::WD_T2_MS : wd_auto;
  assign wd_ok   = wd_eff > wd_base;

  // APB phase decode
  logic setup;
  logic access;
  assign setup  = APB_REQ.psel && !APB_REQ.penable;
  assign access = APB_REQ.psel && APB_REQ.penable;

  // Next-state logic
  always_comb begin
    n = r;
    n.go = 1'b0;
    n.dead = 1'b0;
    n.tick = 1'b0;
    // Bit-period divider
    if (run) begin
      if (r.div_cnt >= div_eff - 12'h001) begin
        n.div_cnt = 12'h000;
        n.tick = 1'b1;
      end else begin
        n.div_cnt = r.div_cnt + 12'h001;
      end
    end else begin
      n.div_cnt = 12'h000;
    end
    // Telegram sequencer
    case (r.st)
      fmbt_pkg::FMBT_IDLE: begin
        n.st = fmbt_pkg::FMBT_READY;
      end
      fmbt_pkg::FMBT_READY: begin
        if (LINK_IN.tx_req) begin
          n.go = 1'b1;
          n.noack = LINK_IN.tx_noack;
          n.st = fmbt_pkg::FMBT_SEND;
        end
      end
      fmbt_pkg::FMBT_SEND: begin
        if (LINK_IN.tx_end) begin
          if (r.noack) begin
            n.cnt = idle2;
            n.st = fmbt_pkg::FMBT_GAP;
          end else begin
            n.cnt = 18'(slot_eff);
            n.st = fmbt_pkg::FMBT_SLOT;
          end
        end
      end
      fmbt_pkg::FMBT_SLOT: begin
        if (LINK_IN.rx_reply) begin
          n.retry_cnt = 4'h0;
          n.rpt = 1'b0;
          n.cnt = idle1;
          n.st = fmbt_pkg::FMBT_GAP;
        end else if (r.cnt == 18'h00000) begin
          n.st = fmbt_pkg::FMBT_READY;
          if (r.retry_cnt < r.cfg.retry) begin
            n.retry_cnt = r.retry_cnt + 4'h1;
            n.rpt = 1'b1;
          end else begin
            n.dead = 1'b1;
            n.retry_cnt = 4'h0;
            n.rpt = 1'b0;
          end
        end else if (r.tick) begin
          n.cnt = r.cnt - 18'h00001;
        end
      end
      fmbt_pkg::FMBT_GAP: begin
        if (r.cnt == 18'h00000) begin
          n.st = fmbt_pkg::FMBT_READY;
        end else if (r.tick) begin
          n.cnt = r.cnt - 18'h00001;
        end
      end
      default: begin
        n.st = fmbt_pkg::FMBT_IDLE;
      end
    endcase
    // Poll address, one per bus cycle
    if (LINK_IN.cycle_end) begin
      n.poll = (r.poll >= r.cfg.hsa) ? 7'h00 : r.poll + 7'h01;
    end
    // Watchdog value and data-exchange gate
    n.wd_out = wd_eff;
    if (LINK_IN.prm_sent && wd_ok) begin
      n.dx = 1'b1;
    end
    if (!run) begin
      n.st = fmbt_pkg::FMBT_IDLE;
      n.retry_cnt = 4'h0;
      n.rpt = 1'b0;
      n.dx = 1'b0;
      n.go = 1'b0;
    end
    // APB read and decode in setup phase
    if (setup) begin
      n.pslverr = 1'b0;
      n.prdata = 32'h00000000;
      case (APB_REQ.paddr)
        fmbt_pkg::OFS_CTRL:     n.prdata = {27'h0, r.cfg.ctrl};
        fmbt_pkg::OFS_SLOT:     n.prdata = {16'h0, r.cfg.slot};
        fmbt_pkg::OFS_TSET:     n.prdata = {16'h0, r.cfg.tset};
        fmbt_pkg::OFS_TQUI:     n.prdata = {16'h0, r.cfg.tqui};
        fmbt_pkg::OFS_TSDR_MIN: n.prdata = {16'h0, r.cfg.tsdr_min};
        fmbt_pkg::OFS_TSDR_MAX: n.prdata = {16'h0, r.cfg.tsdr_max};
        fmbt_pkg::OFS_TID2:     n.prdata = {16'h0, r.cfg.tid2};
        fmbt_pkg::OFS_IDLE1X:   n.prdata = {16'h0, r.cfg.idle1_extra};
        fmbt_pkg::OFS_GAP:      n.prdata = {12'h0, r.cfg.retry, 1'b0, r.cfg.hsa, r.cfg.gap};
        fmbt_pkg::OFS_PAYLOAD:  n.prdata = {8'h0, r.cfg.stations,
                                            r.cfg.response_payload_bytes,
                                            r.cfg.request_payload_bytes};
        fmbt_pkg::OFS_CYCLE:    n.prdata = {r.cfg.field_ms, r.cfg.dp_ms};
        fmbt_pkg::OFS_WDOG:     n.prdata = {16'h0, r.cfg.wd_ms};
        fmbt_pkg::OFS_DELAY:    n.prdata = {16'h0, r.max_delay};
        fmbt_pkg::OFS_STATUS:   n.prdata = {19'h0, r.st, r.retry_cnt, r.rpt, r.dx,
                                            wd_ok, slot_ok, rate_ok, many};
        fmbt_pkg::OFS_TIMING:   n.prdata = {idle2[15:0], idle1[15:0]};
        fmbt_pkg::OFS_RATE:     n.prdata = {4'h0, fmbt_pkg::PA_BIT_CYC, 4'h0, div_eff};
        fmbt_pkg::OFS_WDEFF:    n.prdata = {14'h0, r.wd_out};
        fmbt_pkg::OFS_DIV:      n.prdata = {20'h0, r.cfg.div};
        default:                n.pslverr = 1'b1;
      endcase
    end
    // APB write at the access edge
    if (access && APB_REQ.pwrite && !r.pslverr) begin
      case (APB_REQ.paddr)
        fmbt_pkg::OFS_CTRL:     n.cfg.ctrl = APB_REQ.pwdata[4:0];
        fmbt_pkg::OFS_SLOT:     n.cfg.slot = APB_REQ.pwdata[15:0];
        fmbt_pkg::OFS_TSET:     n.cfg.tset = APB_REQ.pwdata[15:0];
        fmbt_pkg::OFS_TQUI:     n.cfg.tqui = APB_REQ.pwdata[15:0];
        fmbt_pkg::OFS_TSDR_MIN: n.cfg.tsdr_min = APB_REQ.pwdata[15:0];
        fmbt_pkg::OFS_TSDR_MAX: n.cfg.tsdr_max = APB_REQ.pwdata[15:0];
        fmbt_pkg::OFS_TID2:     n.cfg.tid2 = APB_REQ.pwdata[15:0];
        fmbt_pkg::OFS_IDLE1X:   n.cfg.idle1_extra = APB_REQ.pwdata[15:0];
        fmbt_pkg::OFS_GAP: begin
          n.cfg.gap = APB_REQ.pwdata[7:0];
          n.cfg.hsa = APB_REQ.pwdata[14:8];
          n.cfg.retry = APB_REQ.pwdata[19:16];
        end
        fmbt_pkg::OFS_PAYLOAD: begin
          n.cfg.request_payload_bytes = APB_REQ.pwdata[7:0];
          n.cfg.response_payload_bytes = APB_REQ.pwdata[15:8];
          n.cfg.stations = APB_REQ.pwdata[23:16];
        end
        fmbt_pkg::OFS_CYCLE: begin
          n.cfg.dp_ms = APB_REQ.pwdata[15:0];
          n.cfg.field_ms = APB_REQ.pwdata[31:16];
        end
        fmbt_pkg::OFS_WDOG:     n.cfg.wd_ms = APB_REQ.pwdata[15:0];
        fmbt_pkg::OFS_DELAY: begin
          n.max_delay = APB_REQ.pwdata[31] ? 16'h0000 :
                        16'(max18(18'(r.max_delay), 18'(APB_REQ.pwdata[15:0])));
        end
        fmbt_pkg::OFS_DIV:      n.cfg.div = APB_REQ.pwdata[11:0];
        default: begin
        end
      endcase
    end
    // Clock enable freezes everything
    if (!CE) begin
      n = r;
    end
  end

  // State register
  always_ff @(posedge CLK) begin
    if (RST) begin
      r <= '{cfg: fmbt_pkg::CFG_RST, st: fmbt_pkg::FMBT_IDLE, default: '0};
    end else begin
      r <= n;
    end
  end

  // Outputs
  assign PRDATA    = r.prdata;
  assign PREADY    = CE;
  assign PSLVERR   = access && r.pslverr;
  assign TX_GO     = r.go;
  assign TX_RETRY  = r.rpt;
  assign STN_DEAD  = r.dead;
  assign POLL_ADDR = r.poll;
  assign BIT_TICK  = r.tick;
  assign PRM_WD_MS = r.wd_out;
  assign PRM_WD_EN = r.cfg.ctrl[fmbt_pkg::CTRL_WDEN];
  assign DX_ALLOW  = r.dx;

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_fixed_dp_rate: assert property (!type2 |-> div_eff == 12'h42b)
    else $error("DP bit divider not fixed");
  a_tick_spacing: assert property (r.tick && CE && run && !type2 |=> !r.tick [*8])
    else $error("Bit ticks too close");
  a_auto_slot: assert property (r.cfg.ctrl[1] && sum_b >= 9'h0fd |-> slot_eff == 16'h1c18)
    else $error("Large payload slot wrong");
  a_slot_margin: assert property (slot_ok |-> 20'(slot_eff) >= 20'(sum_b) * 20'h0000d +
                                  20'(r.cfg.tsdr_min) * 20'h00003 + 20'h00277)
    else $error("Slot margin check wrong");
  a_idle1_load: assert property (CE && run && r.st == fmbt_pkg::FMBT_SLOT && LINK_IN.rx_reply
                                 |=> r.st == fmbt_pkg::FMBT_GAP && r.cnt == $past(idle1))
    else $error("Idle-1 not loaded after reply");
  a_idle2_noack: assert property (CE && run && r.st == fmbt_pkg::FMBT_SEND && LINK_IN.tx_end &&
                                  r.noack |=> r.cnt == $past(idle2))
    else $error("Idle-2 not loaded");
  a_idle2_pick: assert property (18'(r.cfg.tsdr_max) > idle1 |-> idle2 == 18'(r.cfg.tsdr_max))
    else $error("Max station delay not used");
  a_poll_wrap: assert property (CE && LINK_IN.cycle_end && r.poll >= r.cfg.hsa |=> r.poll == 7'h00)
    else $error("Poll address did not wrap");
  a_dead_slot: assert property (STN_DEAD |-> $past(r.st == fmbt_pkg::FMBT_SLOT && r.cnt == 18'h0))
    else $error("Station dead before slot expiry");
  a_go_ready: assert property (TX_GO |-> $past(r.st == fmbt_pkg::FMBT_READY))
    else $error("Request outside ready state");
  a_retry_bound: assert property (r.retry_cnt <= r.cfg.retry)
    else $error("Retry count above limit");
  a_dx_prm: assert property ($rose(r.dx) |-> $past(LINK_IN.prm_sent && wd_ok))
    else $error("Data exchange without parameterisation");
  a_wd_recommend: assert property (r.cfg.wd_ms == 16'h0 && !type2 |->
                                   wd_eff >= 18'(r.cfg.field_ms) * 18'h00003 &&
                                   wd_eff > worst_case_delay)
    else $error("Auto watchdog too small");

  c_reply: cover property (r.st == fmbt_pkg::FMBT_SLOT && LINK_IN.rx_reply);
  c_dead: cover property (STN_DEAD);
  c_noack: cover property (r.st == fmbt_pkg::FMBT_SEND && LINK_IN.tx_end && r.noack);
  c_dx: cover property ($rose(r.dx));

endmodule

// [common/fmbt_pkg.sv]
package fmbt_pkg;
  // Clock and bit timing
  localparam int unsigned CLK_HZ      = 32'h05f5e100;
  localparam real         CLK_MHZ     = real'(CLK_HZ) / 1.0e6;
  localparam real         DP_KBAUD    = 93.75;
  localparam real         PA_KBAUD    = 31.25;
  localparam logic [11:0] DP_BIT_CYC  = 12'(int'(CLK_MHZ * 1000.0 / DP_KBAUD));
  localparam logic [11:0] PA_BIT_CYC  = 12'(int'(CLK_MHZ * 1000.0 / PA_KBAUD));
  localparam int unsigned T2_MIN_BAUD = 32'h0000b18a;
  localparam int unsigned T2_MAX_BAUD = 32'h00b71b00;
  localparam logic [11:0] T2_DIV_MIN  = 12'((CLK_HZ + T2_MAX_BAUD - 1) / T2_MAX_BAUD);
  localparam logic [11:0] T2_DIV_MAX  = 12'(CLK_HZ / T2_MIN_BAUD);
  // Bus timing figures in DP bit times
  localparam logic [15:0] SLOT_STD       = 16'h0fff;
  localparam logic [15:0] SLOT_BIG       = 16'h1c18;
  localparam logic [8:0]  SLOT_BIG_BYTES = 9'h0fd;
  localparam logic [19:0] SLOT_BYTE_MUL  = 20'h0000d;
  localparam logic [19:0] SLOT_TSDR_MUL  = 20'h00003;
  localparam logic [19:0] SLOT_MARGIN    = 20'h00276;
  localparam logic [17:0] IDLE1_ADD      = 18'h00023;
  // Watchdog figures in ms
  localparam logic [17:0] WD_MUL         = 18'h00003;
  localparam int unsigned WD_T2_S        = 5;
  localparam logic [17:0] WD_T2_MS       = 18'(WD_T2_S * 1000);
  localparam logic [7:0]  MANY_STATIONS  = 8'h20;
  // Control bit positions
  localparam int CTRL_EN     = 0;
  localparam int CTRL_AUTO   = 1;
  localparam int CTRL_T2     = 2;
  localparam int CTRL_WDEN   = 3;
  localparam int CTRL_PERSLV = 4;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_SLOT     = 8'h04;
  localparam logic [7:0] OFS_TSET     = 8'h08;
  localparam logic [7:0] OFS_TQUI     = 8'h0c;
  localparam logic [7:0] OFS_TSDR_MIN = 8'h10;
  localparam logic [7:0] OFS_TSDR_MAX = 8'h14;
  localparam logic [7:0] OFS_TID2     = 8'h18;
  localparam logic [7:0] OFS_IDLE1X   = 8'h1c;
  localparam logic [7:0] OFS_GAP      = 8'h20;
  localparam logic [7:0] OFS_PAYLOAD  = 8'h24;
  localparam logic [7:0] OFS_CYCLE    = 8'h28;
  localparam logic [7:0] OFS_WDOG     = 8'h2c;
  localparam logic [7:0] OFS_DELAY    = 8'h30;
  localparam logic [7:0] OFS_STATUS   = 8'h34;
  localparam logic [7:0] OFS_TIMING   = 8'h38;
  localparam logic [7:0] OFS_RATE     = 8'h3c;
  localparam logic [7:0] OFS_WDEFF    = 8'h40;
  localparam logic [7:0] OFS_DIV      = 8'h44;
  // Sequencer states, Gray along the telegram path
  typedef enum logic [2:0] {
    FMBT_IDLE  = 3'h0,
    FMBT_READY = 3'h1,
    FMBT_SEND  = 3'h3,
    FMBT_SLOT  = 3'h2,
    FMBT_GAP   = 3'h6
  } fmbt_state_t;
  // Port carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } fmbt_apb_req_t;
  typedef struct packed {
    logic tx_req;
    logic tx_noack;
    logic tx_end;
    logic rx_reply;
    logic cycle_end;
    logic prm_sent;
  } fmbt_link_in_t;
  // Configuration registers
  typedef struct packed {
    logic [4:0]  ctrl;
    logic [15:0] slot;
    logic [15:0] tset;
    logic [15:0] tqui;
    logic [15:0] tsdr_min;
    logic [15:0] tsdr_max;
    logic [15:0] tid2;
    logic [15:0] idle1_extra;
    logic [7:0]  gap;
    logic [6:0]  hsa;
    logic [3:0]  retry;
    logic [7:0]  request_payload_bytes;
    logic [7:0]  response_payload_bytes;
    logic [7:0]  stations;
    logic [15:0] dp_ms;
    logic [15:0] field_ms;
    logic [15:0] wd_ms;
    logic [11:0] div;
  } fmbt_cfg_t;
  localparam fmbt_cfg_t CFG_RST = '{ctrl: 5'h00, slot: SLOT_STD, tset: 16'h0037,
    tqui: 16'h0000, tsdr_min: 16'h0016, tsdr_max: 16'h03e8, tid2: 16'h03e8,
    idle1_extra: 16'h0000, gap: 8'h0a, hsa: 7'h7e, retry: 4'h1,
    request_payload_bytes: 8'h00, response_payload_bytes: 8'h00, stations: 8'h00,
    dp_ms: 16'h0000, field_ms: 16'h0000, wd_ms: 16'h0000, div: DP_BIT_CYC};
endpackage

// [test/fmbt_coupler_model.sv]
`timescale 1ns/100ps
// Coupler stand-in: relays each telegram, then answers acknowledged ones after a set delay
module fmbt_coupler_model (
  // Clock
  input  wire logic        clk,
  // Master side
  input  wire logic        tx_go,
  input  wire logic        noack,
  input  wire logic        reply_en,
  input  wire logic [31:0] dly,
  input  wire logic        prm,
  input  wire logic        wd_en,
  input  wire logic [17:0] wd_ms,
  // Relayed events
  output logic             tx_end,
  output logic             rx_reply,
  // Field slave state
  output logic             slave_dx
);
  int unsigned quiet = 0;
  // Unbuffered relay; the field slave answers only acknowledged telegrams
  initial begin
    tx_end = 1'b0;
    rx_reply = 1'b0;
    forever begin
      @(posedge clk);
      if (tx_go === 1'b1) begin
        repeat (20) @(posedge clk);
        tx_end <= 1'b1;
        @(posedge clk);
        tx_end <= 1'b0;
        if (reply_en && !noack) begin
          repeat (dly) @(posedge clk);
          rx_reply <= 1'b1;
          @(posedge clk);
          rx_reply <= 1'b0;
        end
      end
    end
  end
  // Field slave watchdog, one clock standing in for one ms
  always @(posedge clk) begin
    if (prm === 1'b1) begin
      slave_dx <= 1'b1;
      quiet <= 0;
    end else if (tx_go === 1'b1) begin
      quiet <= 0;
    end else if (slave_dx === 1'b1 && wd_en === 1'b1 && quiet >= wd_ms) begin
      slave_dx <= 1'b0;
    end else begin
      quiet <= quiet + 1;
    end
  end
endmodule

// [test/fieldbus_master_bus_timing_tb_top.sv]
`timescale 1ns/100ps
`define CHK(g,e) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module fieldbus_master_bus_timing_tb_top;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  int                      n_fail = 0;
  int                      n_tests = 0;
  int                      cyc = 0;
  int                      n;
  logic [31:0]             rd;
  logic                    err;
  logic                    tx_req = 1'b0;
  logic                    noack = 1'b0;
  logic                    cyc_end = 1'b0;
  logic                    prm = 1'b0;
  logic                    reply_en = 1'b1;
  logic                    ce = 1'b1;
  logic                    slave_dx;
  logic                    BIT_TICK;
  logic                    tx_end;
  logic                    rx_reply;
  fmbt_pkg::fmbt_apb_req_t req = '0;
  fmbt_pkg::fmbt_link_in_t lin;
  logic [31:0]             PRDATA;
  logic                    PREADY;
  logic                    PSLVERR;
  logic                    TX_GO;
  logic                    TX_RETRY;
  logic                    STN_DEAD;
  logic [6:0]              POLL_ADDR;
  logic [17:0]             PRM_WD_MS;
  logic                    PRM_WD_EN;
  logic                    DX_ALLOW;
  // Clock, link inputs
  always #5 clk = ~clk;
  assign lin = {tx_req, noack, tx_end, rx_reply, cyc_end, prm};
  // Block and coupler stand-in
  fmbt_top DUT (.CLK(clk), .RST(rst), .CE(ce), .APB_REQ(req), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .LINK_IN(lin), .TX_GO(TX_GO), .TX_RETRY(TX_RETRY),
    .STN_DEAD(STN_DEAD), .POLL_ADDR(POLL_ADDR), .BIT_TICK(BIT_TICK), .PRM_WD_MS(PRM_WD_MS),
    .PRM_WD_EN(PRM_WD_EN), .DX_ALLOW(DX_ALLOW));
  fmbt_coupler_model cpl (.clk(clk), .tx_go(TX_GO), .noack(noack), .reply_en(reply_en),
    .dly(32'h000002ee), .prm(prm), .wd_en(PRM_WD_EN), .wd_ms(PRM_WD_MS), .tx_end(tx_end),
    .rx_reply(rx_reply), .slave_dx(slave_dx));
  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      n_fail++;
      results();
    end
  end
  // One APB transfer, held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    req <= '0;
    @(posedge clk);
  endtask
  // Write, then let registered outputs settle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    `CHK(rd, e)
  endtask
  // Edges until a signal is seen high
  task automatic wt(ref logic s, output int k);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (s !== 1'b1);
  endtask
  // Two telegrams; cycles from end of the first to permission for the second
  task automatic gapt(input logic na, input int e);
    tx_req <= 1'b1;
    noack <= na;
    if (na) wt(tx_end, n);
    else wt(rx_reply, n);
    wt(TX_GO, n);
    tx_req <= 1'b0;
    `CHK(n inside {[e - 10:e + 30]}, 1'b1)
    if (na) wt(tx_end, n);
    else wt(rx_reply, n);
  endtask
  task automatic t_regs();
    rchk(fmbt_pkg::OFS_SLOT, 32'h00000fff);
    rchk(fmbt_pkg::OFS_TSET, 32'h00000037);
    rchk(fmbt_pkg::OFS_TQUI, 32'h00000000);
    rchk(fmbt_pkg::OFS_TSDR_MIN, 32'h00000016);
    rchk(fmbt_pkg::OFS_GAP, 32'h00017e0a);
    rchk(fmbt_pkg::OFS_TID2, 32'h000003e8);
    rchk(fmbt_pkg::OFS_TSDR_MAX, 32'h000003e8);
    wr(fmbt_pkg::OFS_TIMING, 32'h00000000);
    rchk(fmbt_pkg::OFS_TIMING, 32'h03e80091);
    rchk(fmbt_pkg::OFS_RATE, 32'h0c80042b);
    rchk(8'h48, 32'h00000000);
    `CHK(err, 1'b1)
    $display("t_regs done");
  endtask
  task automatic t_gap();
    wr(fmbt_pkg::OFS_DIV, 32'h0000000a);
    wr(fmbt_pkg::OFS_CTRL, 32'h00000005);
    rchk(fmbt_pkg::OFS_RATE, 32'h0c80000a);
    gapt(1'b0, 1450);
    wr(fmbt_pkg::OFS_IDLE1X, 32'h00000032);
    rchk(fmbt_pkg::OFS_TIMING, 32'h03e800c3);
    gapt(1'b0, 1950);
    wr(fmbt_pkg::OFS_IDLE1X, 32'h00000000);
    gapt(1'b1, 10000);
    wr(fmbt_pkg::OFS_TSDR_MAX, 32'h00000064);
    wr(fmbt_pkg::OFS_TID2, 32'h0000012c);
    rchk(fmbt_pkg::OFS_TIMING, 32'h012c0091);
    gapt(1'b1, 3000);
    $display("t_gap done");
  endtask
  task automatic t_slot();
    wr(fmbt_pkg::OFS_SLOT, 32'h00000028);
    apb(1'b0, fmbt_pkg::OFS_STATUS, '0);
    `CHK(rd[2], 1'b0)
    reply_en <= 1'b0;
    noack <= 1'b0;
    tx_req <= 1'b1;
    wt(tx_end, n);
    wt(TX_GO, n);
    tx_req <= 1'b0;
    `CHK(n inside {[390:430]}, 1'b1)
    `CHK(TX_RETRY, 1'b1)
    wt(STN_DEAD, n);
    `CHK(n inside {[410:460]}, 1'b1)
    reply_en <= 1'b1;
    wr(fmbt_pkg::OFS_SLOT, 32'h00001c18);
    apb(1'b0, fmbt_pkg::OFS_STATUS, '0);
    `CHK(rd[2], 1'b1)
    wr(fmbt_pkg::OFS_TSDR_MIN, 32'h000003e8);
    wr(fmbt_pkg::OFS_CTRL, 32'h00000007);
    wr(fmbt_pkg::OFS_PAYLOAD, 32'h001f7e7e);
    apb(1'b0, fmbt_pkg::OFS_STATUS, '0);
    `CHK(rd[2], 1'b0)
    `CHK(rd[0], 1'b0)
    wr(fmbt_pkg::OFS_PAYLOAD, 32'h00207f7e);
    apb(1'b0, fmbt_pkg::OFS_STATUS, '0);
    `CHK(rd[2], 1'b1)
    `CHK(rd[0], 1'b1)
    $display("t_slot done");
  endtask
  // One bus-cycle end marker, then two edges to settle
  task automatic pulse_cyc();
    cyc_end <= 1'b1;
    @(posedge clk);
    cyc_end <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic t_poll();
    logic [6:0] p;
    p = POLL_ADDR;
    wt(BIT_TICK, n);
    wt(BIT_TICK, n);
    `CHK(n, 10)
    pulse_cyc();
    `CHK(POLL_ADDR, p + 7'h01)
    ce <= 1'b0;
    pulse_cyc();
    `CHK(PREADY, 1'b0)
    `CHK(POLL_ADDR, p + 7'h01)
    ce <= 1'b1;
    wr(fmbt_pkg::OFS_GAP, 32'h0001010a);
    pulse_cyc();
    `CHK(POLL_ADDR, 7'h00)
    $display("t_poll done");
  endtask
  task automatic t_wdog();
    wr(fmbt_pkg::OFS_CYCLE, 32'h000a0005);
    wr(fmbt_pkg::OFS_CTRL, 32'h0000000d);
    `CHK(PRM_WD_MS, 18'h01388)
    `CHK(PRM_WD_EN, 1'b1)
    wr(fmbt_pkg::OFS_WDOG, 32'h0000000c);
    wr(fmbt_pkg::OFS_CTRL, 32'h00000009);
    prm <= 1'b1;
    @(posedge clk);
    prm <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(DX_ALLOW, 1'b0)
    wr(fmbt_pkg::OFS_WDOG, 32'h00000000);
    `CHK(PRM_WD_MS, 18'h0001e)
    wr(fmbt_pkg::OFS_DELAY, 32'h00000028);
    `CHK(PRM_WD_MS, 18'h00029)
    wr(fmbt_pkg::OFS_CTRL, 32'h00000019);
    `CHK(PRM_WD_MS, 18'h0001e)
    prm <= 1'b1;
    @(posedge clk);
    prm <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(DX_ALLOW, 1'b1)
    `CHK(slave_dx, 1'b1)
    repeat (40) @(posedge clk);
    `CHK(slave_dx, 1'b0)
    wr(fmbt_pkg::OFS_CTRL, 32'h00000000);
    `CHK(DX_ALLOW, 1'b0)
    $display("t_wdog done");
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_gap();
    t_slot();
    t_poll();
    t_wdog();
    results();
  end
endmodule
